// file: logic/srg_pkg.sv
/*
  Package for the supply reset generator: hold delay options, timing
  constants and state encodings.
  Assumes a 40 MHz core clock; used by srg_top and srg_apb.
*/
package srg_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned HOLD_US_OPT0  = 1400;
  localparam int unsigned HOLD_US_OPT1  = 30000;
  localparam int unsigned HOLD_US_OPT2  = 200000;
  localparam int unsigned HOLD_US_OPT3  = 1600000;
  localparam logic [1:0]  HOLD_SEL_STD  = 2'h2;
  localparam int unsigned CNT_W         = 27;

  // Least times round up to whole cycles
  function automatic logic [CNT_W-1:0] srg_us_to_cycles(input int unsigned us);
    longint unsigned prod;
    prod = (longint'(us) * longint'(CLK_HZ) + 64'd999999) / 64'd1000000;
    return prod[CNT_W-1:0];
  endfunction

  localparam logic [CNT_W-1:0] HOLD_CYC_OPT0 = srg_us_to_cycles(HOLD_US_OPT0);
  localparam logic [CNT_W-1:0] HOLD_CYC_OPT1 = srg_us_to_cycles(HOLD_US_OPT1);
  localparam logic [CNT_W-1:0] HOLD_CYC_OPT2 = srg_us_to_cycles(HOLD_US_OPT2);
  localparam logic [CNT_W-1:0] HOLD_CYC_OPT3 = srg_us_to_cycles(HOLD_US_OPT3);

  // APB register map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_PU_BIT  = 2;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0006;

  typedef enum logic [1:0] {
    SRG_POWERUP,
    SRG_ASSERTED,
    SRG_HOLDING,
    SRG_RELEASED
  } srg_state_t;
endpackage

// file: logic/srg_apb.sv
/*
  APB slave for the supply reset generator: a control word (hold delay
  select, internal pull-up fitted) and a read-only status word.
  Assumes an APB master on core_clk_in; zero wait states.
*/
`timescale 1ns/10ps
module srg_apb (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] status_in,
  output logic      [31:0] prdata_out,
  output logic             pslverr_out,
  output logic      [1:0]  hold_sel_out,
  output logic             pullup_fit_out
);
  logic [31:0] ctrl;
  wire         access   = psel_in & penable_in;
  wire         hit_ctrl = (paddr_in == srg_pkg::REG_CTRL);
  wire         hit_stat = (paddr_in == srg_pkg::REG_STATUS);
  wire         mapped   = hit_ctrl | hit_stat;
  wire  [31:0] rd_mux   = hit_ctrl ? ctrl : (hit_stat ? status_in : 32'h0000_0000);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ctrl        <= srg_pkg::CTRL_RESET;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
    else
    begin
      // Registered answer on the setup cycle so it is ready in access
      prdata_out  <= rd_mux;
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      if (access && pwrite_in && hit_ctrl)
        ctrl <= {29'h0, pwdata_in[srg_pkg::CTRL_PU_BIT], pwdata_in[1:0]};
    end
  end

  assign hold_sel_out   = ctrl[srg_pkg::CTRL_SEL_LSB +: 2];
  assign pullup_fit_out = ctrl[srg_pkg::CTRL_PU_BIT];
endmodule // srg_apb

// file: logic/srg_top.sv
/*
  Supply reset generator top: merges supply, push-button, watchdog and
  power-up causes into one reset condition, stretches it by the hold
  delay, and drives active-low and active-high reset pins.
  Assumes the comparator and watchdog deliver levels synchronous to
  core_clk_in; rst_in stands for power-up.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
// Functional notes
// - Reset is active while push-button is low or watchdog has expired.
// - Supply below trip point forces every reset output active at once.
// - On rising supply, reset persists until above trip plus hysteresis.
// - Outputs stay active for full hold delay after all causes clear.
// - Hold count starts when all causes clear; expiry releases the outputs.
// - Hold delay options 1.4 ms, 30 ms, 200 ms, 1.6 s; default 200 ms.
// - Active-low output low in reset; active-high output is the inverse.
// - Active-high output push-pull; only active-low may be open-drain.
// - Internal pull-up disconnected whenever open-drain output drives low.
// - Output valid and active from power-up until supply clears.
`timescale 1ns/10ps
module srg_top #(
  parameter logic [srg_pkg::CNT_W-1:0] HOLD_CYC_0 = srg_pkg::HOLD_CYC_OPT0,
  parameter logic [srg_pkg::CNT_W-1:0] HOLD_CYC_1 = srg_pkg::HOLD_CYC_OPT1,
  parameter logic [srg_pkg::CNT_W-1:0] HOLD_CYC_2 = srg_pkg::HOLD_CYC_OPT2,
  parameter logic [srg_pkg::CNT_W-1:0] HOLD_CYC_3 = srg_pkg::HOLD_CYC_OPT3,
  parameter bit                        OPEN_DRAIN = 1'b1
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        supply_below_trip_in,
  input  wire logic        supply_above_hys_in,
  input  wire logic        pushbutton_reset_n_in,
  input  wire logic        watchdog_expired_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             reset_n_out,
  output logic             reset_n_oe_out,
  output logic             reset_out,
  output logic             pullup_en_out
);
  localparam int W = srg_pkg::CNT_W;

  srg_pkg::srg_state_t state;
  srg_pkg::srg_state_t next_state;
  logic [W-1:0]        hold_cnt;
  logic [W-1:0]        next_hold_cnt;
  logic                supply_low;
  logic                next_supply_low;
  logic [1:0]          hold_sel;
  logic                pullup_fit;
  logic [31:0]         status_word;

  // Hysteresis latch: set below trip, cleared only above trip plus margin
  assign next_supply_low = supply_below_trip_in ? 1'b1 :
                           (supply_above_hys_in ? 1'b0 : supply_low);

  // Live causes; supply_below_trip acts combinationally so no cycle is lost
  wire cause = ~pushbutton_reset_n_in | watchdog_expired_in
             | supply_below_trip_in | next_supply_low;

  wire [W-1:0] hold_target = (hold_sel == 2'h0) ? HOLD_CYC_0 :
                             (hold_sel == 2'h1) ? HOLD_CYC_1 :
                             (hold_sel == 2'h2) ? HOLD_CYC_2 : HOLD_CYC_3;

  wire hold_done = (hold_cnt >= hold_target - W'(1));

  always_comb
  begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    case (state)
      srg_pkg::SRG_POWERUP, srg_pkg::SRG_ASSERTED:
      begin
        next_hold_cnt = '0;
        if (!cause)
          next_state = srg_pkg::SRG_HOLDING;
        else
          next_state = srg_pkg::SRG_ASSERTED;
      end
      srg_pkg::SRG_HOLDING:
      begin
        if (cause)
        begin
          next_state    = srg_pkg::SRG_ASSERTED;
          next_hold_cnt = '0;
        end
        else if (hold_done)
          next_state = srg_pkg::SRG_RELEASED;
        else
          next_hold_cnt = hold_cnt + W'(1);
      end
      srg_pkg::SRG_RELEASED:
      begin
        next_hold_cnt = '0;
        if (cause)
          next_state = srg_pkg::SRG_ASSERTED;
      end
      default:
      begin
        next_state    = srg_pkg::SRG_ASSERTED;
        next_hold_cnt = '0;
      end
    endcase
  end

  wire next_active = (next_state != srg_pkg::SRG_RELEASED);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state      <= srg_pkg::SRG_POWERUP;
      hold_cnt   <= '0;
      supply_low <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      hold_cnt   <= next_hold_cnt;
      supply_low <= next_supply_low;
    end
  end

  // Pins registered from the next state so they change with the state
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      reset_n_out    <= 1'b0;
      reset_n_oe_out <= 1'b1;
      reset_out      <= 1'b1;
      pullup_en_out  <= 1'b0;
      pready_out     <= 1'b0;
    end
    else
    begin
      reset_n_out    <= ~next_active;
      reset_n_oe_out <= OPEN_DRAIN ? next_active : 1'b1;
      reset_out      <= next_active;
      pullup_en_out  <= OPEN_DRAIN & pullup_fit & ~next_active;
      pready_out     <= psel_in & ~penable_in;
    end
  end

  assign status_word = {27'h0, supply_low, ~pushbutton_reset_n_in,
                        watchdog_expired_in, state};

  srg_apb u_apb (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .psel_in        (psel_in),
    .penable_in     (penable_in),
    .pwrite_in      (pwrite_in),
    .paddr_in       (paddr_in),
    .pwdata_in      (pwdata_in),
    .status_in      (status_word),
    .prdata_out     (prdata_out),
    .pslverr_out    (pslverr_out),
    .hold_sel_out   (hold_sel),
    .pullup_fit_out (pullup_fit)
  );

  sequence cause_seen_s;
    !rst_in && cause;
  endsequence

  supply_trip_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    supply_below_trip_in |=> (reset_out && !reset_n_out))
    else $error("Supply trip did not assert reset");

  hys_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (supply_low && !supply_above_hys_in) |=> reset_out)
    else $error("Reset released before hysteresis cleared");

  cause_active_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cause_seen_s |=> reset_out)
    else $error("Cause did not hold reset");

  polarity_pair_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    reset_out == !reset_n_out)
    else $error("Reset outputs disagree");

  pullup_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !reset_n_out |-> !pullup_en_out)
    else $error("Pull-up on while driving low");

  hold_full_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ($fell(reset_out)) |-> ($past(state) == srg_pkg::SRG_HOLDING && $past(hold_done)))
    else $error("Released before hold delay");

  restart_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == srg_pkg::SRG_HOLDING && cause) |=> (hold_cnt == '0 && reset_out))
    else $error("Hold not restarted");

  od_drive_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (OPEN_DRAIN && !reset_out) |-> !reset_n_oe_out)
    else $error("Open-drain driving when inactive");

  start_count_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == srg_pkg::SRG_HOLDING && !cause && !hold_done) |=> hold_cnt == $past(hold_cnt) + W'(1))
    else $error("Hold counter stalled");
endmodule // srg_top

// file: bench/srg_host.sv
/*
  Host controller held in reset by the generator.
  Assumes the resolved active-low pin and the active-high pin.
*/
`timescale 1ns/10ps
module srg_host (
  input  wire logic clk_in,
  input  wire logic reset_n_pin_in,
  input  wire logic reset_in,
  output int        releases_out
);
  logic was_held;

  initial releases_out = 0;
  initial was_held = 1'b1;
  // Counts only clean exits where both pins agree
  always @(posedge clk_in)
  begin
    if (was_held && reset_n_pin_in === 1'b1 && reset_in === 1'b0)
      releases_out <= releases_out + 1;
    was_held <= (reset_n_pin_in !== 1'b1);
  end
endmodule // srg_host

// file: bench/tb_srg_top.sv
/*
  Self-checking bench for the supply reset generator with shortened holds.
  Assumes srg_top, srg_pkg and srg_host are compiled first.
*/
`timescale 1ns/10ps
module tb_srg_top;
  localparam int H[4] = '{20, 30, 40, 50};
  logic        clk = 0, rst = 1, blw = 1, abv = 0, pb_n = 1, wd = 0;
  logic        psel = 0, pen = 0, pwr = 0, prdy, perr, rn, rnoe, rh, pu, pin, er;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  int          n_errors = 0, checks_done = 0, releases, k;

  always #12.5 clk = ~clk;
  // External pull-up stands in when the pin is released
  assign pin = rnoe ? rn : 1'b1;
  srg_top #(.HOLD_CYC_0(27'd20), .HOLD_CYC_1(27'd30), .HOLD_CYC_2(27'd40), .HOLD_CYC_3(27'd50),
    .OPEN_DRAIN(1'b1)) srg_top_i (.core_clk_in(clk), .rst_in(rst), .supply_below_trip_in(blw),
    .supply_above_hys_in(abv), .pushbutton_reset_n_in(pb_n), .watchdog_expired_in(wd), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .reset_n_out(rn), .reset_n_oe_out(rnoe), .reset_out(rh),
    .pullup_en_out(pu));
  srg_host srg_host_i (.clk_in(clk), .reset_n_pin_in(pin), .reset_in(rh), .releases_out(releases));

  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    // Read before the edge's updates land: the values the slave showed at it
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 16);
    cmp("pready", 32'h1, {31'h0, prdy});
    rd = prd;
    er = perr;
    {psel, pen} <= 2'b00;
  endtask

  // Pins as seen mid-cycle: active-high, active-low, its enable, pull-up
  task pins(input logic act, input logic fit);
    @(negedge clk);
    cmp("pins", {28'h0, act, ~act, act, ~act & fit}, {28'h0, rh, rn, rnoe, pu});
  endtask

  task cause(input int c, input logic on);
    case (c)
      0: pb_n <= ~on;
      1: wd <= on;
      default: {blw, abv} <= {on, ~on};
    endcase
  endtask

  // Cause for a while, clear, then watch the hold window
  task pulse_hold(input int c, input int h, input logic fit);
    @(posedge clk);
    cause(c, 1'b1);
    repeat (2 + $urandom_range(0, 18)) @(posedge clk);
    pins(1'b1, fit);
    @(posedge clk);
    cause(c, 1'b0);
    repeat (h) @(posedge clk);
    pins(1'b1, fit);
    @(posedge clk);
    pins(1'b0, fit);
  endtask

  always @(negedge clk)
    if (!rst)
      cmp("polarity", {31'h0, ~rn}, {31'h0, rh});

  initial
  begin
    #500000;
    n_errors++;
    give_verdict;
  end

  initial
  begin
    void'($urandom(32'h33edcd4c));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pins(1'b1, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    cmp("ctrl reset", 32'h0000_0006, rd);
    cmp("mapped err", 32'h0, {31'h0, er});
    apb(1'b0, 12'h004, 32'h0);
    cmp("supply latch", 32'h1, {31'h0, rd[4]});
    // Below trip cleared but not above hysteresis: must stay held
    blw <= 1'b0;
    repeat (100) @(posedge clk);
    pins(1'b1, 1'b1);
    @(posedge clk);
    abv <= 1'b1;
    repeat (H[2]) @(posedge clk);
    pins(1'b1, 1'b1);
    @(posedge clk);
    pins(1'b0, 1'b1);
    apb(1'b1, 12'h008, $urandom);
    cmp("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h008, 32'h0);
    cmp("unmapped read", 32'h0, rd);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, 12'h000, 32'h4 | k);
      apb(1'b0, 12'h000, 32'h0);
      cmp("ctrl", 32'h4 | k, rd);
      pulse_hold($urandom_range(0, 2), H[k], 1'b1);
    end
    // Second cause inside the hold restarts the full delay
    @(posedge clk);
    cause(0, 1'b1);
    repeat (3) @(posedge clk);
    cause(0, 1'b0);
    repeat (H[3] / 2) @(posedge clk);
    pulse_hold(1, H[3], 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    pulse_hold(2, H[0], 1'b0);
    cmp("host releases", 32'd7, releases);
    give_verdict;
  end
endmodule // tb_srg_top
